// >>> hdl/uart_swfc_pkg.sv
// Constants and types of the software flow control channel
//
// Function
// - All flow-select bits zero: no flow control
// - Bits 3:2 pick transmitted pause/resume characters
// - Bits 1:0 pick receive comparison characters
// - Rx 11 with tx 10/01: either char accepted
// - Rx 11 with tx 11/00: first-second sequence only
// - Four write-only pause/resume character registers
// - Status forced zero while flow control disabled
// - Status bit 3: last sent was resume
// - Status bit 2: last sent was pause
// - Status bit 1: last received was resume
// - Status bit 0: last received was pause
// - Status indicator bits clear on host read
// - Divisor bytes init at power-up only
// - Modem status: low clear, high from pins
// - Special detect, second pair: pause2 dropped, flagged
package uart_swfc_pkg;
   localparam logic [3:0] A_DATA   = 4'h0;
   localparam logic [3:0] A_EFC    = 4'h1;
   localparam logic [3:0] A_PAUSE1 = 4'h2;
   localparam logic [3:0] A_PAUSE2 = 4'h3;
   localparam logic [3:0] A_RESUM1 = 4'h4;
   localparam logic [3:0] A_RESUM2 = 4'h5;
   localparam logic [3:0] A_STATUS = 4'h6;
   localparam logic [3:0] A_DIVLO  = 4'h7;
   localparam logic [3:0] A_DIVHI  = 4'h8;
   localparam logic [3:0] A_MODEM  = 4'h9;
   localparam logic [3:0] A_INTST  = 4'ha;
   localparam logic [3:0] A_LINE   = 4'hb;
   localparam logic [3:0] A_SCRAT  = 4'hc;
   localparam logic [3:0] A_MODCTL = 4'hd;
   localparam int B_SPECIAL = 5;
   localparam int B_TXON  = 3;
   localparam int B_TXOFF = 2;
   localparam int B_RXON  = 1;
   localparam int B_RXOFF = 0;
   localparam int B_THRE  = 5;
   localparam int B_TEMT  = 6;
   localparam int B_DTR   = 0;
   localparam int B_RTS   = 1;
   localparam int B_BREAK = 2;
   localparam logic [1:0] SEL_NONE   = 2'h0;
   localparam logic [1:0] SEL_SECOND = 2'h1;
   localparam logic [1:0] SEL_FIRST  = 2'h2;
   localparam logic [1:0] SEL_BOTH   = 2'h3;
   localparam logic [7:0] RST_ZERO  = 8'h00;
   localparam logic [7:0] RST_INTST = 8'h01;
   localparam logic [7:0] RST_LINE  = 8'h60;
   localparam logic [7:0] RST_SCRAT = 8'hff;
   localparam logic [7:0] RST_DIVLO = 8'h01;
   localparam logic [7:0] RST_DIVHI = 8'h00;
   localparam int FIFO_DEPTH = 4;
   localparam int CHAR_W     = 8;

   typedef enum logic [1:0] {TX_IDLE, TX_SEND2} tx_state_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] data;
   } host_req_t;

   typedef struct packed {
      logic [7:0] dll;
      logic [7:0] divisor_high_byte;
   } divisor_t;
endpackage

// >>> hdl/uart_swfc.sv
// Software flow control channel with transmit FIFO
`timescale 1ns/1ps
`default_nettype none

module uart_swfc_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   // Clock and reset
   input  wire logic         core_clk_i,
   input  wire logic         reset_i,
   // Fill side
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   // Drain side
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } fifo_state_t;
   fifo_state_t s_q, s_d;
   logic push, pop;

   // Depth must be a power of two so the pointers wrap
   assign in_ready_o  = s_q.cnt != (AW+1)'(D);
   assign out_valid_o = s_q.cnt != '0;
   assign out_data_o  = s_q.mem[s_q.rp];
   assign push = in_valid_i && in_ready_o;
   assign pop  = out_valid_o && out_ready_i;

   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wp] = in_data_i;
         s_d.wp = s_q.wp + 1'b1;
      end
      if (pop) begin
         s_d.rp = s_q.rp + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////

module uart_swfc
   import uart_swfc_pkg::*;
(
   // Clock and resets
   input  wire logic        core_clk_i,
   input  wire logic        reset_i,
   input  wire logic        por_i,
   // Host register port
   input  wire host_req_t   host_i,
   output logic [7:0]       rdata_o,
   // Flow requests from receive level logic
   input  wire logic        pause_req_i,
   input  wire logic        resume_req_i,
   // Transmit character stream
   output logic [7:0]       tx_char_o,
   output logic             tx_valid_o,
   input  wire logic        tx_ready_i,
   // Receive character stream
   input  wire logic [7:0]  rx_char_i,
   input  wire logic        rx_valid_i,
   output logic [7:0]       rx_char_o,
   output logic             rx_valid_o,
   // Event pulses
   output logic             pause_irq_o,
   output logic             special_irq_o,
   // Modem pins
   input  wire logic [3:0]  modem_i,
   output logic             tx_o,
   output logic             rts_n_o,
   output logic             dtr_n_o
);
   typedef struct packed {
      logic [7:0] efc;
      logic [7:0] pause1;
      logic [7:0] pause2;
      logic [7:0] resum1;
      logic [7:0] resum2;
      logic [7:0] status;
      logic [7:0] scrat;
      logic [7:0] modctl;
      logic [7:0] intst;
      logic [7:0] line;
      logic [7:0] modem;
      logic [3:0] pin_s1;
      logic [3:0] pin_s2;
      logic       pins_live;
      logic [1:0] warm;
      logic [7:0] rdata;
      tx_state_t  tx_state;
      logic       tx_pause;
      logic [7:0] tx_char;
      logic       tx_valid;
      logic       pend_pause;
      logic       pend_resume;
      logic       paused;
      logic       prev_p1;
      logic       prev_r1;
      logic [7:0] rx_char;
      logic       rx_valid;
      logic       pause_irq;
      logic       special_irq;
      logic       tx_line;
      logic       rts_n;
      logic       dtr_n;
   } chan_state_t;

   chan_state_t s_q, s_d;
   divisor_t    div_q, div_d;

   logic       fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [7:0] fifo_out_data;
   logic       tx_load, tx_ctrl_sent, tx_ctrl_pause;
   logic       rx_pause_det, rx_resume_det, rd_status;
   logic [1:0] rx_sel, tx_sel;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction

   uart_swfc_fifo #(
      .W(CHAR_W),
      .D(FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i  (core_clk_i),
      .reset_i     (reset_i),
      .in_valid_i  (host_i.wr && host_i.addr == A_DATA),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (host_i.data),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_out_data)
   );

   assign rx_sel    = s_q.efc[1:0];
   assign tx_sel    = s_q.efc[3:2];
   assign rd_status = host_i.rd && host_i.addr == A_STATUS;
   assign tx_load   = !s_q.tx_valid || tx_ready_i;

   ////////////////////////////////////////////////////////////////////

   always_comb begin
      logic p1, p2, r1, r2, either, keep;
      s_d = s_q;
      p1 = hit(rx_char_i, s_q.pause1);
      p2 = hit(rx_char_i, s_q.pause2);
      r1 = hit(rx_char_i, s_q.resum1);
      r2 = hit(rx_char_i, s_q.resum2);
      either = tx_sel == SEL_FIRST || tx_sel == SEL_SECOND;
      keep = 1'b0;
      rx_pause_det  = 1'b0;
      rx_resume_det = 1'b0;
      tx_ctrl_sent  = 1'b0;
      tx_ctrl_pause = 1'b0;
      fifo_pop      = 1'b0;

      // Host writes
      if (host_i.wr) begin
         case (host_i.addr)
            A_EFC:    s_d.efc    = host_i.data;
            A_PAUSE1: s_d.pause1 = host_i.data;
            A_PAUSE2: s_d.pause2 = host_i.data;
            A_RESUM1: s_d.resum1 = host_i.data;
            A_RESUM2: s_d.resum2 = host_i.data;
            A_SCRAT:  s_d.scrat  = host_i.data;
            A_MODCTL: s_d.modctl = host_i.data;
            default: ;
         endcase
      end

      // Receive comparison
      case (rx_sel)
         SEL_FIRST: begin
            rx_pause_det  = p1;
            rx_resume_det = r1;
         end
         SEL_SECOND: begin
            rx_pause_det  = p2;
            rx_resume_det = r2;
         end
         SEL_BOTH: begin
            if (either) begin
               rx_pause_det  = p1 || p2;
               rx_resume_det = r1 || r2;
            end else begin
               rx_pause_det  = s_q.prev_p1 && p2;
               rx_resume_det = s_q.prev_r1 && r2;
            end
         end
         default: ;
      endcase
      rx_pause_det  = rx_pause_det && rx_valid_i;
      rx_resume_det = rx_resume_det && rx_valid_i;

      s_d.rx_valid    = 1'b0;
      s_d.pause_irq   = rx_pause_det;
      s_d.special_irq = 1'b0;
      if (rx_valid_i) begin
         s_d.prev_p1 = p1;
         s_d.prev_r1 = r1;
         // Pause2 with special detect on the second pair is dropped
         keep = !(rx_pause_det || rx_resume_det);
         s_d.special_irq = s_q.efc[B_SPECIAL] && p2;
         s_d.rx_valid = keep;
         s_d.rx_char  = rx_char_i;
      end
      if (rx_pause_det) begin
         s_d.paused = 1'b1;
      end
      if (rx_resume_det || rx_sel == SEL_NONE) begin
         s_d.paused = 1'b0;
      end

      // Transmit: control characters take priority over data
      if (pause_req_i) begin
         s_d.pend_pause = 1'b1;
      end
      if (resume_req_i) begin
         s_d.pend_resume = 1'b1;
      end
      if (tx_ready_i) begin
         s_d.tx_valid = 1'b0;
      end
      if (tx_load) begin
         case (s_q.tx_state)
            TX_SEND2: begin
               s_d.tx_char  = s_q.tx_pause ? s_q.pause2 : s_q.resum2;
               s_d.tx_valid = 1'b1;
               s_d.tx_state = TX_IDLE;
            end
            TX_IDLE: begin
               if (tx_sel != SEL_NONE &&
                   (s_q.pend_pause || s_q.pend_resume)) begin
                  tx_ctrl_sent  = 1'b1;
                  tx_ctrl_pause = s_q.pend_pause;
                  s_d.tx_pause  = s_q.pend_pause;
                  s_d.tx_valid  = 1'b1;
                  if (s_q.pend_pause) begin
                     s_d.pend_pause = pause_req_i;
                  end else begin
                     s_d.pend_resume = resume_req_i;
                  end
                  if (tx_sel == SEL_SECOND) begin
                     s_d.tx_char = s_q.pend_pause ? s_q.pause2
                                                  : s_q.resum2;
                  end else begin
                     s_d.tx_char = s_q.pend_pause ? s_q.pause1
                                                  : s_q.resum1;
                  end
                  if (tx_sel == SEL_BOTH) begin
                     s_d.tx_state = TX_SEND2;
                  end
               end else if (fifo_out_valid && !s_q.paused) begin
                  fifo_pop     = 1'b1;
                  s_d.tx_char  = fifo_out_data;
                  s_d.tx_valid = 1'b1;
               end
            end
            default: s_d.tx_state = TX_IDLE;
         endcase
      end
      // Requests are meaningless with transmit selection off
      if (tx_sel == SEL_NONE) begin
         s_d.pend_pause  = 1'b0;
         s_d.pend_resume = 1'b0;
      end

      // Status: read clears, a new event in the same cycle wins
      if (rd_status) begin
         s_d.status = RST_ZERO;
      end
      if (tx_ctrl_sent) begin
         s_d.status[B_TXON]  = !tx_ctrl_pause;
         s_d.status[B_TXOFF] = tx_ctrl_pause;
      end
      if (rx_pause_det || rx_resume_det) begin
         s_d.status[B_RXON]  = rx_resume_det;
         s_d.status[B_RXOFF] = rx_pause_det;
      end
      s_d.status[7:4] = 4'h0;
      if (s_d.efc[3:0] == 4'h0) begin
         s_d.status = RST_ZERO;
      end

      // Modem status: pins after two flops, deltas clear on read
      s_d.pin_s1 = modem_i;
      s_d.pin_s2 = s_q.pin_s1;
      // No deltas until the high bits hold real pin levels
      s_d.warm = {s_q.warm[0], 1'b1};
      s_d.pins_live = s_q.warm[1];
      if (host_i.rd && host_i.addr == A_MODEM) begin
         s_d.modem[3:0] = 4'h0;
      end
      if (s_q.pins_live) begin
         s_d.modem[3:0] = s_d.modem[3:0] | (s_q.pin_s2 ^ s_q.modem[7:4]);
      end
      s_d.modem[7:4] = s_q.pin_s2;

      // Line status reflects the transmit path
      s_d.line[B_THRE] = fifo_in_ready;
      s_d.line[B_TEMT] = !fifo_out_valid && !s_d.tx_valid;

      s_d.tx_line = !s_q.modctl[B_BREAK];
      s_d.rts_n   = !s_q.modctl[B_RTS];
      s_d.dtr_n   = !s_q.modctl[B_DTR];

      // Write-only registers read back as zero
      case (host_i.addr)
         A_EFC:    s_d.rdata = s_q.efc;
         A_STATUS: s_d.rdata = s_q.status;
         A_DIVLO:  s_d.rdata = div_q.dll;
         A_DIVHI:  s_d.rdata = div_q.divisor_high_byte;
         A_MODEM:  s_d.rdata = s_q.modem;
         A_INTST:  s_d.rdata = s_q.intst;
         A_LINE:   s_d.rdata = s_q.line;
         A_SCRAT:  s_d.rdata = s_q.scrat;
         A_MODCTL: s_d.rdata = s_q.modctl;
         default:  s_d.rdata = RST_ZERO;
      endcase
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_q         <= '0;
         s_q.intst   <= RST_INTST;
         s_q.line    <= RST_LINE;
         s_q.scrat   <= RST_SCRAT;
         s_q.tx_line <= 1'b1;
         s_q.rts_n   <= 1'b1;
         s_q.dtr_n   <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////

   // Divisor survives the reset pin; only power-up resets it
   always_comb begin
      div_d = div_q;
      if (host_i.wr && host_i.addr == A_DIVLO) begin
         div_d.dll = host_i.data;
      end
      if (host_i.wr && host_i.addr == A_DIVHI) begin
         div_d.divisor_high_byte = host_i.data;
      end
   end

   always_ff @(posedge core_clk_i or posedge por_i) begin
      if (por_i) begin
         div_q <= {RST_DIVLO, RST_DIVHI};
      end else begin
         div_q <= div_d;
      end
   end

   assign rdata_o       = s_q.rdata;
   assign tx_char_o     = s_q.tx_char;
   assign tx_valid_o    = s_q.tx_valid;
   assign rx_char_o     = s_q.rx_char;
   assign rx_valid_o    = s_q.rx_valid;
   assign pause_irq_o   = s_q.pause_irq;
   assign special_irq_o = s_q.special_irq;
   assign tx_o          = s_q.tx_line;
   assign rts_n_o       = s_q.rts_n;
   assign dtr_n_o       = s_q.dtr_n;

   ////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   a_status_off: assert property (
      s_q.efc[3:0] == 4'h0 |-> s_q.status == RST_ZERO)
      else $error("status not zero with flow control off");
   a_no_tx_ctrl: assert property (
      tx_sel == SEL_NONE |-> !tx_ctrl_sent)
      else $error("control char sent with selection off");
   a_tx_flags: assert property (
      tx_ctrl_sent && !tx_ctrl_pause |=> s_q.status[3:2] == 2'b10)
      else $error("resume sent flag wrong");
   a_rx_flags: assert property (
      rx_pause_det && s_d.efc[3:0] != 4'h0 |=> s_q.status[1:0] == 2'b01)
      else $error("pause received flag wrong");
   a_read_clear: assert property (
      rd_status && !tx_ctrl_sent && !rx_pause_det && !rx_resume_det
      |=> s_q.status == RST_ZERO)
      else $error("status not cleared by read");
   a_seq_second: assert property (
      tx_ctrl_sent && tx_sel == SEL_BOTH && !tx_ctrl_pause
      ##1 tx_ready_i |=> tx_valid_o && tx_char_o == s_q.resum2)
      else $error("second sequence char wrong");
   a_either_char: assert property (
      rx_valid_i && rx_sel == SEL_BOTH && tx_sel == SEL_FIRST
      && rx_char_i == s_q.pause2 |-> rx_pause_det)
      else $error("second pause not accepted");
   a_special_drop: assert property (
      rx_valid_i && s_q.efc[B_SPECIAL] && rx_sel == SEL_SECOND
      && rx_char_i == s_q.pause2
      |=> pause_irq_o && special_irq_o && !rx_valid_o)
      else $error("special pause handling wrong");
   a_div_keep: assert property (
      @(posedge core_clk_i) disable iff (por_i)
      reset_i && !host_i.wr |=> div_q == $past(div_q))
      else $error("divisor changed by reset pin");
   a_modem_high: assert property (
      s_q.pins_live |=> s_q.modem[7:4] == $past(s_q.pin_s2))
      else $error("modem status high bits not from pins");
endmodule

`default_nettype wire

// >>> verification/uart_remote_model.sv
// Remote serial station: takes sent characters, sends received ones
`timescale 1ns/1ps
`default_nettype none

module uart_remote_model (
   // Clock
   input  wire logic       core_clk_i,
   // Characters from the channel
   input  wire logic [7:0] tx_char_i,
   input  wire logic       tx_valid_i,
   output logic            tx_ready_o,
   // Pace control from the bench
   input  wire logic       stall_i,
   input  wire logic       slow_i,
   // Characters into the channel
   output logic [7:0]      rx_char_o,
   output logic            rx_valid_o
);
   logic [7:0] got_q[$];

   initial begin
      tx_ready_o = 1'b0;
      rx_char_o  = 8'h00;
      rx_valid_o = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // Slow mode takes every other cycle to expose pairing gaps
   always @(posedge core_clk_i) begin
      if (tx_valid_i && tx_ready_o) begin
         got_q.push_back(tx_char_i);
      end
      #1 tx_ready_o <= !stall_i && !(slow_i && tx_ready_o);
   end

   ////////////////////////////////////////////////////////////////////
   // Idle line shows the inverted char, never a stale copy
   task automatic send(input logic [7:0] c);
      @(posedge core_clk_i);
      #1;
      rx_char_o  = c;
      rx_valid_o = 1'b1;
      @(posedge core_clk_i);
      #1;
      rx_char_o  = ~c;
      rx_valid_o = 1'b0;
   endtask
endmodule

`default_nettype wire

// >>> verification/uart_swfc_tb.sv
// Self-checking bench for the software flow control channel
`timescale 1ns/1ps
`default_nettype none

module uart_swfc_tb;
   import uart_swfc_pkg::*;
   localparam logic [7:0] C_P1 = 8'h13;
   localparam logic [7:0] C_P2 = 8'h93;
   localparam logic [7:0] C_R1 = 8'h11;
   localparam logic [7:0] C_R2 = 8'h91;
   logic       core_clk_i;
   logic       reset_i;
   logic       por_i;
   host_req_t  host_i;
   logic [7:0] rdata_o;
   logic       pause_req_i;
   logic       resume_req_i;
   logic [7:0] tx_char_o;
   logic       tx_valid_o;
   logic       tx_ready_i;
   logic [7:0] rx_char_i;
   logic       rx_valid_i;
   logic [7:0] rx_char_o;
   logic       rx_valid_o;
   logic       pause_irq_o;
   logic       special_irq_o;
   logic [3:0] modem_i;
   logic       tx_o;
   logic       rts_n_o;
   logic       dtr_n_o;
   logic       stall;
   logic       slow;
   logic [7:0] d;
   logic [7:0] e[$];
   int         n_fail;
   int         n_checks;
   int         n_pirq;
   int         n_sirq;
   int         n_rxv;
   logic [7:0] rx_last;

   uart_swfc i_uart_swfc (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .por_i(por_i),
      .host_i(host_i), .rdata_o(rdata_o), .pause_req_i(pause_req_i),
      .resume_req_i(resume_req_i), .tx_char_o(tx_char_o),
      .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
      .rx_char_i(rx_char_i), .rx_valid_i(rx_valid_i),
      .rx_char_o(rx_char_o), .rx_valid_o(rx_valid_o),
      .pause_irq_o(pause_irq_o), .special_irq_o(special_irq_o),
      .modem_i(modem_i), .tx_o(tx_o), .rts_n_o(rts_n_o),
      .dtr_n_o(dtr_n_o)
   );

   uart_remote_model i_uart_remote_model (
      .core_clk_i(core_clk_i), .tx_char_i(tx_char_o),
      .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i),
      .stall_i(stall), .slow_i(slow), .rx_char_o(rx_char_i),
      .rx_valid_o(rx_valid_i)
   );

   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end

   // Event pulses last one cycle, so count them at every edge
   always @(posedge core_clk_i) begin
      if (pause_irq_o === 1'b1) n_pirq = n_pirq + 1;
      if (special_irq_o === 1'b1) n_sirq = n_sirq + 1;
      if (rx_valid_o === 1'b1) begin
         n_rxv = n_rxv + 1;
         rx_last = rx_char_o;
      end
   end

   ////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] s, x);
      n_checks++;
      if (s !== x) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, x, s);
      end
   endtask

   // Extra idle edge so back-to-back calls never rewrite host_i at once
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      host_i = '{wr: 1'b1, rd: 1'b0, addr: a, data: v};
      @(posedge core_clk_i);
      #1;
      host_i = '0;
      @(posedge core_clk_i);
      #1;
   endtask

   task automatic rchk(input string nm, input logic [3:0] a,
                       input logic [7:0] x);
      host_i = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
      @(posedge core_clk_i);
      #1;
      d = rdata_o;
      host_i = '0;
      chk(nm, d, x);
      @(posedge core_clk_i);
      #1;
   endtask

   task automatic cmp_q;
      int i;
      for (i = 0; i < 80; i++) begin
         if (i_uart_remote_model.got_q.size() >= e.size()) break;
         @(posedge core_clk_i);
      end
      if (i == 80) begin
         n_fail++;
         end_of_test();
      end
      repeat (4) @(posedge core_clk_i);
      #1;
      chk("tx count", 8'(i_uart_remote_model.got_q.size()), 8'(e.size()));
      foreach (e[k]) begin
         if (i_uart_remote_model.got_q.size() > 0)
            chk("tx char", i_uart_remote_model.got_q.pop_front(), e[k]);
      end
   endtask

   task automatic tx_case(input bit res, input logic [1:0] s);
      e.delete();
      if (s[1]) e.push_back(res ? C_R1 : C_P1);
      if (s[0]) e.push_back(res ? C_R2 : C_P2);
      wr(A_EFC, 8'h00);
      wr(A_EFC, {4'h0, s, 2'b00});
      slow = res;
      pause_req_i = !res;
      resume_req_i = res;
      @(posedge core_clk_i);
      #1;
      pause_req_i = 1'b0;
      resume_req_i = 1'b0;
      cmp_q();
      rchk("tx status", A_STATUS,
           s == 2'b00 ? 8'h00 : res ? 8'h08 : 8'h04);
      rchk("status read", A_STATUS, 8'h00);
   endtask

   task automatic rx_case(input logic [7:0] f, c0, c, st, input int np, nf);
      wr(A_EFC, 8'h00);
      wr(A_EFC, f);
      n_pirq = 0;
      n_sirq = 0;
      n_rxv = 0;
      rx_last = 8'h00;
      if (c0 != 8'h00) i_uart_remote_model.send(c0);
      i_uart_remote_model.send(c);
      repeat (2) @(posedge core_clk_i);
      #1;
      chk("pause event", 8'(n_pirq), 8'(np));
      chk("forwarded", 8'(n_rxv), 8'(nf));
      chk("rx char", rx_last,
          nf == 0 ? 8'h00 : c0 != 8'h00 ? c0 : c);
      rchk("rx status", A_STATUS, st);
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      n_fail = 0;
      n_checks = 0;
      n_pirq = 0;
      n_sirq = 0;
      n_rxv = 0;
      host_i = '0;
      pause_req_i = 1'b0;
      resume_req_i = 1'b0;
      modem_i = 4'ha;
      stall = 1'b0;
      slow = 1'b0;
      reset_i = 1'b1;
      por_i = 1'b1;
      repeat (10) @(posedge core_clk_i);
      #1;
      chk("pins", {5'h00, tx_o, rts_n_o, dtr_n_o}, 8'h07);
      reset_i = 1'b0;
      por_i = 1'b0;
      repeat (4) @(posedge core_clk_i);
      #1;
      rchk("int status", A_INTST, RST_INTST);
      rchk("line", A_LINE, RST_LINE);
      rchk("scratch", A_SCRAT, RST_SCRAT);
      rchk("feature", A_EFC, 8'h00);
      rchk("status", A_STATUS, 8'h00);
      rchk("div low", A_DIVLO, RST_DIVLO);
      rchk("div high", A_DIVHI, RST_DIVHI);
      rchk("unmapped", 4'hf, 8'h00);
      rchk("modem", A_MODEM, 8'ha0);
      // Pin reset taken in mid-run, divisor must survive it
      wr(A_DIVLO, 8'h5a);
      wr(A_SCRAT, 8'h3c);
      wr(A_MODCTL, 8'h07);
      chk("pins driven", {5'h00, tx_o, rts_n_o, dtr_n_o}, 8'h00);
      modem_i = 4'h5;
      reset_i = 1'b1;
      @(posedge core_clk_i);
      #1;
      chk("pins reset", {5'h00, tx_o, rts_n_o, dtr_n_o}, 8'h07);
      reset_i = 1'b0;
      repeat (4) @(posedge core_clk_i);
      #1;
      rchk("div kept", A_DIVLO, 8'h5a);
      rchk("scratch reset", A_SCRAT, RST_SCRAT);
      rchk("modem reset", A_MODEM, 8'h50);
      wr(A_PAUSE1, C_P1);
      wr(A_PAUSE2, C_P2);
      wr(A_RESUM1, C_R1);
      wr(A_RESUM2, C_R2);
      for (int a = 2; a < 6; a++) rchk("write only", 4'(a), 8'h00);
      // Fill the FIFO against a stalled partner until it refuses
      stall = 1'b1;
      e.delete();
      for (int i = 0; i < 8; i++) begin
         rchk("line poll", A_LINE, i == 0 ? RST_LINE :
              i <= FIFO_DEPTH ? 8'h20 : 8'h00);
         if (!d[B_THRE]) break;
         wr(A_DATA, 8'(8'h40 + i));
         e.push_back(8'(8'h40 + i));
      end
      chk("fifo full", {7'h00, d[B_THRE]}, 8'h00);
      wr(A_DATA, 8'hee);
      stall = 1'b0;
      cmp_q();
      rchk("drained", A_LINE, RST_LINE);
      for (int s = 0; s < 4; s++) begin
         tx_case(1'b0, 2'(s));
         tx_case(1'b1, 2'(s));
      end
      rx_case(8'h02, 8'h00, C_P1, 8'h01, 1, 0);
      rx_case(8'h02, 8'h00, C_R1, 8'h02, 0, 0);
      rx_case(8'h02, 8'h00, C_P2, 8'h00, 0, 1);
      rx_case(8'h01, 8'h00, C_P2, 8'h01, 1, 0);
      rx_case(8'h01, 8'h00, C_R2, 8'h02, 0, 0);
      rx_case(8'h0b, 8'h00, C_P2, 8'h01, 1, 0);
      rx_case(8'h07, 8'h00, C_R1, 8'h02, 0, 0);
      rx_case(8'h0f, 8'h00, C_P2, 8'h00, 0, 1);
      rx_case(8'h03, C_R1, C_R2, 8'h02, 0, 1);
      rx_case(8'h0f, C_P1, C_P2, 8'h01, 1, 1);
      rx_case(8'h21, 8'h00, C_P2, 8'h01, 1, 0);
      chk("special", 8'(n_sirq), 8'h01);
      wr(A_EFC, 8'h00);
      wr(A_EFC, 8'h02);
      i_uart_remote_model.send(C_P1);
      wr(A_EFC, 8'h00);
      rchk("status off", A_STATUS, 8'h00);
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge core_clk_i);
      n_fail++;
      end_of_test();
   end
endmodule

`default_nettype wire
